// file: usp_pkg.sv
package usp_pkg;
  // Hardware reset hold, in system clock periods
  localparam int RESET_MIN_CYCLES = 6;
  localparam logic [2:0] RESET_HOLD_LAST = 3'(RESET_MIN_CYCLES - 1);
  // Line setup byte field positions
  localparam int STOP_POS = 6;
  localparam int PARITY_POS = 4;
  localparam int LENGTH_POS = 2;
  localparam int RATE_POS = 0;
  localparam int SYNC_COUNT_POS = 7;
  localparam int SYNC_SOURCE_POS = 6;
  // Clock rate field codes
  localparam logic [1:0] RATE_SYNC = 2'h0;
  localparam logic [1:0] RATE_X16 = 2'h2;
  localparam logic [1:0] RATE_X64 = 2'h3;
  localparam logic [6:0] DIV_X1 = 7'h01;
  localparam logic [6:0] DIV_X16 = 7'h10;
  localparam logic [6:0] DIV_X64 = 7'h40;
  // Command byte bits
  localparam int CMD_TX_ENABLE_POS = 0;
  localparam int CMD_SOFT_RESET_POS = 6;
  // Status byte bits
  localparam int STAT_TX_FREE_POS = 0;
  localparam int STAT_RX_WAIT_POS = 1;
  localparam int STAT_DRAINED_POS = 2;
  // Values after reset and on refused reads
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] REFUSED_READ = 8'h00;
  // Active bit-clock level per link: bit0 transmit (falling), bit1 receive (rising)
  localparam logic [1:0] LINK_EDGE_LEVEL = 2'h2;
  // Host register map (byte addresses)
  localparam logic [7:0] REG_RESET_CTRL = 8'h00;
  localparam logic [7:0] REG_PORT_WRITE = 8'h04;
  localparam logic [7:0] REG_PORT_READ = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int PORT_SEL_POS = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    SEQ_STANDBY = 5'h01,
    SEQ_SYNC1 = 5'h02,
    SEQ_SYNC2 = 5'h04,
    SEQ_FIRST_CMD = 5'h08,
    SEQ_RUN = 5'h10
  } usp_seq_t;

  typedef enum logic [4:0] {
    HST_IDLE = 5'h01,
    HST_RESET = 5'h02,
    HST_WRITE = 5'h04,
    HST_READ = 5'h08,
    HST_CAPTURE = 5'h10
  } usp_host_state_t;

  // Keep the low n data bits; length codes 0..3 mean 5..8 bits
  function automatic logic [7:0] usp_mask_char(input logic [1:0] len, input logic [7:0] value);
    usp_mask_char = value & (8'hFF >> (2'h3 - len));
  endfunction : usp_mask_char
endpackage : usp_pkg

// file: usp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usp_if;
  // Parallel host port
  logic cmd_sel;
  logic rd_n;
  logic wr_n;
  logic chip_reset;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic [7:0] data_bus;
  // Ready request pins
  logic transmit_holding_free;
  logic receive_char_waiting;
  // Bit clocks, made by the bench
  logic transmit_bit_clock;
  logic receive_bit_clock;

  // Shared data bus level; an undriven bus reads as zero
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'h00);

  modport device (
    input cmd_sel, rd_n, wr_n, chip_reset, data_bus, transmit_bit_clock, receive_bit_clock,
    output dev_data, dev_data_oe, transmit_holding_free, receive_char_waiting
  );
  modport host (
    output cmd_sel, rd_n, wr_n, chip_reset, host_data, host_data_oe,
    input data_bus, transmit_holding_free, receive_char_waiting
  );
endinterface : usp_if
`default_nettype wire

// file: usp_device.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module usp_device (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Host port
  usp_if.device bus,
  // Transmit engine side
  output logic [7:0] tx_char,
  output logic tx_char_full,
  input wire logic tx_take,
  input wire logic transmitter_drained,
  output logic tx_baud_tick,
  // Receive engine side
  input wire logic [7:0] rx_char_in,
  input wire logic rx_put,
  output logic rx_baud_tick,
  // Stored setup
  output logic [7:0] line_setup_byte,
  output logic [7:0] command_byte,
  output logic [7:0] sync_char_first,
  output logic [7:0] sync_char_second,
  // Decoded setup fields
  output logic sync_mode,
  output logic parity_enable,
  output logic parity_even,
  output logic [1:0] char_length_field,
  output logic [1:0] stop_bit_field,
  output logic [1:0] clock_rate_field,
  output logic sync_count_bit,
  output logic sync_source_bit
);
  import usp_pkg::*;

  usp_seq_t seq;
  usp_seq_t next_seq;
  logic rst;
  logic ctl_wr;
  logic dat_wr;
  logic ctl_rd;
  logic dat_rd;
  logic any_rd;
  logic in_cmd;
  logic running;
  logic standby;
  logic sw_reset;
  logic rx_waiting;
  logic [7:0] rx_buf;
  logic [7:0] status_byte;
  logic [7:0] status_now;
  logic [7:0] read_value;
  logic [6:0] divisor;
  logic [1:0] link_tick;

  assign rst = !aresetn || bus.chip_reset;

  // port select decode; strobes are one-cycle low pulses
  assign ctl_wr = !bus.wr_n && bus.cmd_sel;
  assign dat_wr = !bus.wr_n && !bus.cmd_sel;
  assign ctl_rd = !bus.rd_n && bus.cmd_sel;
  assign dat_rd = !bus.rd_n && !bus.cmd_sel;
  assign any_rd = ctl_rd || dat_rd;
  assign standby = seq == SEQ_STANDBY;
  assign in_cmd = (seq == SEQ_FIRST_CMD) || (seq == SEQ_RUN);
  assign running = seq == SEQ_RUN;
  assign sw_reset = ctl_wr && in_cmd && bus.data_bus[CMD_SOFT_RESET_POS];

  assign stop_bit_field = line_setup_byte[STOP_POS +: 2];
  assign parity_enable = line_setup_byte[PARITY_POS];
  // high parity bit picks even over odd
  assign parity_even = line_setup_byte[PARITY_POS + 1];
  assign char_length_field = line_setup_byte[LENGTH_POS +: 2];
  assign clock_rate_field = line_setup_byte[RATE_POS +: 2];
  // sync mode on rate code 00
  assign sync_mode = clock_rate_field == RATE_SYNC;
  assign sync_count_bit = line_setup_byte[SYNC_COUNT_POS];
  assign sync_source_bit = line_setup_byte[SYNC_SOURCE_POS];

  // Sequencer; data-port accesses never move it
  always_comb begin
    next_seq = seq;
    case (seq)
      SEQ_STANDBY: begin
        if (ctl_wr) begin
          next_seq = (bus.data_bus[RATE_POS +: 2] == RATE_SYNC) ? SEQ_SYNC1 : SEQ_FIRST_CMD;
        end
      end
      SEQ_SYNC1: begin
        if (ctl_wr) begin
          next_seq = sync_count_bit ? SEQ_FIRST_CMD : SEQ_SYNC2;
        end
      end
      SEQ_SYNC2: begin
        if (ctl_wr) begin
          next_seq = SEQ_FIRST_CMD;
        end
      end
      SEQ_FIRST_CMD, SEQ_RUN: begin
        if (ctl_wr) begin
          next_seq = sw_reset ? SEQ_STANDBY : SEQ_RUN;
        end
      end
      default: begin
        next_seq = SEQ_STANDBY;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      seq <= SEQ_STANDBY;
    end else begin
      seq <= next_seq;
    end
  end

  // Setup and sync storage; kept across soft reset until rewritten
  always_ff @(posedge aclk) begin
    if (rst) begin
      line_setup_byte <= BYTE_RESET;
      sync_char_first <= BYTE_RESET;
      sync_char_second <= BYTE_RESET;
    end else begin
      if (ctl_wr && standby) begin
        line_setup_byte <= bus.data_bus;
      end
      if (ctl_wr && (seq == SEQ_SYNC1)) begin
        sync_char_first <= bus.data_bus;
      end
      if (ctl_wr && (seq == SEQ_SYNC2)) begin
        sync_char_second <= bus.data_bus;
      end
    end
  end

  // command store, cleared by soft reset
  always_ff @(posedge aclk) begin
    if (rst || sw_reset) begin
      command_byte <= BYTE_RESET;
    end else if (ctl_wr && in_cmd) begin
      command_byte <= bus.data_bus;
    end
  end

  // transmit holding keeps only n bits; a new write wins over a take
  always_ff @(posedge aclk) begin
    if (rst || sw_reset) begin
      tx_char <= BYTE_RESET;
      tx_char_full <= 1'b0;
    end else if (dat_wr && running) begin
      tx_char <= usp_mask_char(char_length_field, bus.data_bus);
      tx_char_full <= 1'b1;
    end else if (tx_take) begin
      tx_char_full <= 1'b0;
    end
  end

  // receive flag: arrival wins over a read in the same cycle
  always_ff @(posedge aclk) begin
    if (rst || sw_reset) begin
      rx_buf <= BYTE_RESET;
      rx_waiting <= 1'b0;
    end else if (rx_put) begin
      rx_buf <= usp_mask_char(char_length_field, rx_char_in);
      rx_waiting <= 1'b1;
    end else if (dat_rd && running) begin
      rx_waiting <= 1'b0;
    end
  end

  // request pins for polling or an interrupt controller
  assign bus.transmit_holding_free = !tx_char_full && command_byte[CMD_TX_ENABLE_POS] && running;
  assign bus.receive_char_waiting = rx_waiting;

  // Live status; the upper bits are held at zero, with no engine input
  always_comb begin
    status_now = BYTE_RESET;
    status_now[STAT_TX_FREE_POS] = !tx_char_full;
    status_now[STAT_RX_WAIT_POS] = rx_waiting;
    status_now[STAT_DRAINED_POS] = transmitter_drained;
  end

  // snapshot lags one clock, frozen while a read is answered
  always_ff @(posedge aclk) begin
    if (rst) begin
      status_byte <= BYTE_RESET;
    end else if (!any_rd) begin
      status_byte <= status_now;
    end
  end

  // standby and pre-command data reads give a fixed byte
  assign read_value = dat_rd ? (running ? rx_buf : REFUSED_READ) : (standby ? REFUSED_READ : status_byte);

  // Read answer drives the bus for exactly one clock
  always_ff @(posedge aclk) begin
    if (rst) begin
      bus.dev_data <= BYTE_RESET;
      bus.dev_data_oe <= 1'b0;
    end else begin
      bus.dev_data_oe <= any_rd;
      if (any_rd) begin
        bus.dev_data <= read_value;
      end
    end
  end

  // bit clock divider; sync and times-one count every edge
  assign divisor = (clock_rate_field == RATE_X64) ? DIV_X64 : ((clock_rate_field == RATE_X16) ? DIV_X16 : DIV_X1);

  // Bit clocks come from outside: three stages, change taken when stages two and three agree
  for (genvar i = 0; i < 2; i++) begin : g_link
    logic raw;
    logic [2:0] stage;
    logic level;
    logic hit;
    logic [6:0] count;
    logic tick;
    assign raw = (i == 0) ? bus.transmit_bit_clock : bus.receive_bit_clock;
    assign hit = (stage[1] == stage[2]) && (stage[2] != level) && (stage[2] == LINK_EDGE_LEVEL[i]);
    assign link_tick[i] = tick;

    // Synchroniser and settled level
    always_ff @(posedge aclk) begin
      if (rst) begin
        stage <= 3'h0;
        level <= 1'b0;
      end else begin
        stage <= {stage[1:0], raw};
        if (stage[1] == stage[2]) begin
          level <= stage[2];
        end
      end
    end

    // one tick per divisor active edges
    always_ff @(posedge aclk) begin
      if (rst) begin
        count <= 7'h00;
        tick <= 1'b0;
      end else begin
        tick <= hit && (count >= divisor - 7'h01);
        if (hit) begin
          count <= (count >= divisor - 7'h01) ? 7'h00 : count + 7'h01;
        end
      end
    end
  end

  assign tx_baud_tick = link_tick[0];
  assign rx_baud_tick = link_tick[1];
endmodule : usp_device
`default_nettype wire

// file: usp_host.sv
`timescale 1ns/1ps
`default_nettype none
module usp_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Device port
  usp_if.host bus,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import usp_pkg::*;

  usp_host_state_t state;
  usp_host_state_t next_state;
  logic aw_held;
  logic w_held;
  logic w_lane;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic wr_go;
  logic idle;
  logic map_ok;
  logic rd_map_ok;
  logic op_reset;
  logic op_write;
  logic op_read;
  logic [2:0] reset_cnt;
  logic [7:0] read_byte;
  logic [31:0] read_value;

  // Write channels are taken in either order, one write in flight
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_go = aw_held && w_held && !bvalid;
  assign idle = state == HST_IDLE;
  assign map_ok = (aw_addr == REG_RESET_CTRL) || (aw_addr == REG_PORT_WRITE) || (aw_addr == REG_PORT_READ);
  // Orders only start from idle; the lowest byte lane carries them
  assign op_reset = wr_go && idle && w_lane && (aw_addr == REG_RESET_CTRL) && w_data[0];
  // software issues sync characters before commands, in order
  assign op_write = wr_go && idle && w_lane && (aw_addr == REG_PORT_WRITE);
  assign op_read = wr_go && idle && w_lane && (aw_addr == REG_PORT_READ);

  // Address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_lane <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_lane <= wstrb[0];
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // Busy or unmapped writes answer SLVERR and do nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= (map_ok && idle) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Register read decode
  assign rd_map_ok = (araddr == REG_RESET_CTRL) || (araddr == REG_PORT_READ) || (araddr == REG_STATUS);
  assign read_value = (araddr == REG_RESET_CTRL) ? {31'h0, state == HST_RESET} :
                      (araddr == REG_PORT_READ) ? {24'h0, read_byte} :
                      (araddr == REG_STATUS) ? {29'h0, bus.receive_char_waiting, bus.transmit_holding_free, !idle} :
                      32'h0000_0000;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= read_value;
      rresp <= rd_map_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Device port sequencer
  always_comb begin
    next_state = state;
    case (state)
      HST_IDLE: begin
        if (op_reset) begin
          next_state = HST_RESET;
        end else if (op_write) begin
          next_state = HST_WRITE;
        end else if (op_read) begin
          next_state = HST_READ;
        end
      end
      HST_RESET: begin
        if (reset_cnt == RESET_HOLD_LAST) begin
          next_state = HST_IDLE;
        end
      end
      HST_WRITE: begin
        next_state = HST_IDLE;
      end
      HST_READ: begin
        next_state = HST_CAPTURE;
      end
      HST_CAPTURE: begin
        next_state = HST_IDLE;
      end
      default: begin
        next_state = HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= HST_IDLE;
      reset_cnt <= 3'h0;
    end else begin
      state <= next_state;
      reset_cnt <= (state == HST_RESET) ? reset_cnt + 3'h1 : 3'h0;
    end
  end

  // Pins are registered from the next state, so each strobe is one clock wide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.chip_reset <= 1'b0;
      bus.wr_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.host_data_oe <= 1'b0;
      bus.cmd_sel <= 1'b0;
      bus.host_data <= 8'h00;
    end else begin
      // reset line follows the reset state
      bus.chip_reset <= next_state == HST_RESET;
      bus.wr_n <= next_state != HST_WRITE;
      bus.rd_n <= next_state != HST_READ;
      bus.host_data_oe <= next_state == HST_WRITE;
      if (op_write || op_read) begin
        bus.cmd_sel <= w_data[PORT_SEL_POS];
      end
      if (op_write) begin
        bus.host_data <= w_data[7:0];
      end
    end
  end

  // Device answer is on the bus during the capture clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_byte <= 8'h00;
    end else if (state == HST_CAPTURE) begin
      read_byte <= bus.data_bus;
    end
  end
endmodule : usp_host
`default_nettype wire

// file: usp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module usp_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Parallel port
  input wire logic cmd_sel,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic chip_reset,
  input wire logic host_data_oe,
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe,
  // Ready requests
  input wire logic transmit_holding_free,
  input wire logic receive_char_waiting
);
  import usp_pkg::*;
  logic fresh;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Standby after any reset until the first control write; soft reset is not tracked here
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_reset) begin
      fresh <= 1'h1;
    end else if (!wr_n && cmd_sel) begin
      fresh <= 1'h0;
    end
  end
  AST_READ_ANSWER: assert property (!rd_n |=> dev_data_oe)
    else $error("read strobe not answered");
  AST_OE_CAUSE: assert property (dev_data_oe |-> $past(rd_n) == 1'h0)
    else $error("read answer without strobe");
  AST_CHIP_RESET: assert property (chip_reset |=> !transmit_holding_free && !receive_char_waiting)
    else $error("ready outputs survive reset");
  AST_RESET_WIDTH: assert property ($rose(chip_reset) |-> chip_reset [*6])
    else $error("device reset too short");
  AST_STANDBY_READ: assert property (fresh && !rd_n |=> dev_data == REFUSED_READ)
    else $error("read answered in standby");
  AST_STANDBY_TX: assert property (fresh |-> !transmit_holding_free)
    else $error("transmit ready in standby");
  AST_WRITE_DRIVE: assert property (!wr_n |-> host_data_oe && !dev_data_oe && rd_n)
    else $error("write cycle bus conflict");
  AST_STROBE_PULSE: assert property (!wr_n |=> wr_n)
    else $error("write strobe too long");
  AST_RX_DROP: assert property (receive_char_waiting && !rd_n && !cmd_sel |=> !receive_char_waiting)
    else $error("receive ready kept after read");
  // Main scenarios seen
  cover property (!rd_n && cmd_sel && !fresh);
  cover property ($fell(receive_char_waiting));
  cover property ($rose(chip_reset));
endmodule : usp_chk
`default_nettype wire

// file: test_usart_host_port_mode_setup.sv
`timescale 1ns/1ps
`default_nettype none
module test_usart_host_port_mode_setup;
  import usp_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_char_in = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, char_length_field, stop_bit_field, clock_rate_field;
  logic tx_take = 1'h0, rx_put = 1'h0, transmitter_drained = 1'h1;
  logic [7:0] tx_char, line_setup_byte, command_byte, sync_char_first, sync_char_second;
  logic tx_char_full, tx_baud_tick, rx_baud_tick, sync_mode, parity_enable, parity_even;
  logic sync_count_bit, sync_source_bit;
  logic [8:0] x;
  int miscompares = 0, total_checks = 0, tcnt = 0, rcnt = 0;
  usp_if ifc ();
  usp_device i_usp_device (.aclk, .aresetn, .bus(ifc.device), .tx_char, .tx_char_full, .tx_take,
    .transmitter_drained, .tx_baud_tick, .rx_char_in, .rx_put, .rx_baud_tick, .line_setup_byte,
    .command_byte, .sync_char_first, .sync_char_second, .sync_mode, .parity_enable, .parity_even,
    .char_length_field, .stop_bit_field, .clock_rate_field, .sync_count_bit, .sync_source_bit);
  usp_host i_usp_host (.aclk, .aresetn, .bus(ifc.host), .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  usp_chk i_usp_chk (.aclk, .aresetn, .cmd_sel(ifc.cmd_sel), .rd_n(ifc.rd_n), .wr_n(ifc.wr_n),
    .chip_reset(ifc.chip_reset), .host_data_oe(ifc.host_data_oe), .dev_data(ifc.dev_data),
    .dev_data_oe(ifc.dev_data_oe), .transmit_holding_free(ifc.transmit_holding_free),
    .receive_char_waiting(ifc.receive_char_waiting));
  // System clock; bit clocks free-running and out of phase with each other
  // bench bit clocks, rates scaled to the fast system clock
  always #2.5 aclk = ~aclk;
  always #32 ifc.transmit_bit_clock = ~ifc.transmit_bit_clock;
  initial begin
    ifc.transmit_bit_clock = 1'h0;
    ifc.receive_bit_clock = 1'h0;
    #11;
    forever #32 ifc.receive_bit_clock = ~ifc.receive_bit_clock;
  end
  // Baud tick tallies
  always @(posedge aclk) begin
    tcnt <= tcnt + int'(tx_baud_tick);
    rcnt <= rcnt + int'(rx_baud_tick);
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Both write channels offered at once, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, pb;
    @(posedge aclk);
    {pa, pw, pb} = 3'h7;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    while (pa || pw || pb) begin
      @(posedge aclk);
      if (pa && awready) begin
        awvalid <= 1'h0;
        pa = 1'h0;
      end
      if (pw && wready) begin
        wvalid <= 1'h0;
        pw = 1'h0;
      end
      if (pb && bvalid) begin
        r = bresp;
        bready <= 1'h0;
        pb = 1'h0;
      end
    end
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, pr;
    @(posedge aclk);
    {pa, pr} = 2'h3;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (pa || pr) begin
      @(posedge aclk);
      if (pa && arready) begin
        arvalid <= 1'h0;
        pa = 1'h0;
      end
      if (pr && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        pr = 1'h0;
      end
    end
  endtask : axr
  // Poll bit 0 of a register until the host reports done
  task automatic idle(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h1;
    while (d[0] !== 1'h0) axr(a, d, r);
  endtask : idle
  task automatic pwr(input logic s, input logic [7:0] c);
    logic [1:0] r;
    axw(REG_PORT_WRITE, {23'h0, s, c}, r);
    chk("port write resp", r, RESP_OKAY);
    idle(REG_STATUS);
  endtask : pwr
  task automatic prd(input logic s, output logic [7:0] b);
    logic [31:0] d;
    logic [1:0] r;
    axw(REG_PORT_READ, {23'h0, s, 8'h00}, r);
    idle(REG_STATUS);
    axr(REG_PORT_READ, d, r);
    b = d[7:0];
  endtask : prd
  task automatic pulse_rx(input logic [7:0] c);
    @(posedge aclk);
    rx_char_in <= c;
    rx_put <= 1'h1;
    @(posedge aclk);
    rx_put <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask : pulse_rx
  // Tick counts over a span of link clock edges; slack covers divider phase
  task automatic ticks(input int edges, input int lo, input int hi);
    int t0, r0;
    t0 = tcnt;
    r0 = rcnt;
    repeat (edges) @(negedge ifc.transmit_bit_clock);
    repeat (8) @(posedge aclk);
    chk("tx ticks", (tcnt - t0 >= lo) && (tcnt - t0 <= hi), 1'h1);
    chk("rx ticks", (rcnt - r0 >= lo) && (rcnt - r0 <= hi), 1'h1);
  endtask : ticks
  task automatic t_async();
    logic [7:0] b;
    logic [31:0] d;
    logic [1:0] r;
    axw(REG_RESET_CTRL, 32'h1, r);
    idle(REG_RESET_CTRL);
    prd(1'h1, b);
    chk("standby status", b, REFUSED_READ);
    pwr(1'h0, 8'h55);
    chk("standby data write", tx_char_full, 1'h0);
    pwr(1'h1, 8'hFA);
    x = {stop_bit_field, parity_even, parity_enable, char_length_field, clock_rate_field, sync_mode};
    chk("setup fields", x, {2'h3, 1'h1, 1'h1, 2'h2, 2'h2, 1'h0});
    pwr(1'h1, 8'h01);
    chk("first command", {line_setup_byte, command_byte}, 16'hFA01);
    axr(REG_STATUS, d, r);
    chk("ready flags", d[2:1], 2'h1);
    pwr(1'h0, 8'hFF);
    chk("masked tx", {tx_char_full, tx_char}, 9'h17F);
    chk("tx ready pin", ifc.transmit_holding_free, 1'h0);
    @(posedge aclk);
    tx_take <= 1'h1;
    @(posedge aclk);
    tx_take <= 1'h0;
    pulse_rx(8'hA5);
    chk("rx ready pin", ifc.receive_char_waiting, 1'h1);
    prd(1'h0, b);
    chk("rx masked", b, 8'h25);
    chk("rx pin drop", ifc.receive_char_waiting, 1'h0);
    prd(1'h1, b);
    chk("status", b, 8'h05);
    transmitter_drained <= 1'h0;
    prd(1'h1, b);
    chk("status not drained", b, 8'h01);
    transmitter_drained <= 1'h1;
    ticks(64, 3, 5);
    $display("async test done");
  endtask : t_async
  task automatic t_soft();
    logic [7:0] b;
    pulse_rx(8'h3C);
    pwr(1'h1, 8'h40);
    chk("soft reset", {command_byte, ifc.transmit_holding_free, ifc.receive_char_waiting}, 10'h000);
    prd(1'h1, b);
    chk("standby status", b, REFUSED_READ);
    pwr(1'h1, 8'h4D);
    x = {stop_bit_field, parity_even, parity_enable, char_length_field, clock_rate_field, sync_mode};
    chk("x1 fields", x, {2'h1, 1'h0, 1'h0, 2'h3, 2'h1, 1'h0});
    pwr(1'h1, 8'h01);
    ticks(16, 14, 18);
    $display("soft reset test done");
  endtask : t_soft
  task automatic t_sync();
    logic [7:0] b;
    pwr(1'h1, 8'h40);
    pwr(1'h1, 8'h10);
    x = {stop_bit_field, parity_even, parity_enable, char_length_field, clock_rate_field, sync_mode};
    chk("sync fields", x, {2'h0, 1'h0, 1'h1, 2'h0, 2'h0, 1'h1});
    pwr(1'h1, 8'h16);
    chk("sync one", {command_byte, sync_char_first}, 16'h0016);
    pwr(1'h1, 8'h17);
    chk("sync two", {command_byte, sync_char_second}, 16'h0017);
    pwr(1'h1, 8'h01);
    prd(1'h1, b);
    chk("sync command", {command_byte, b}, 16'h0105);
    pwr(1'h1, 8'h40);
    pwr(1'h1, 8'hC0);
    chk("sync bits", {sync_count_bit, sync_source_bit}, 2'h3);
    pwr(1'h1, 8'h33);
    pwr(1'h1, 8'h05);
    chk("one sync", {sync_char_first, command_byte}, 16'h3305);
    $display("sync test done");
  endtask : t_sync
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    axr(8'h10, d, r);
    chk("unmapped read resp", r, RESP_SLVERR);
    chk("unmapped read data", d, 32'h0);
    axw(8'h10, 32'h0, r);
    chk("unmapped write", r, RESP_SLVERR);
    $display("bus test done");
  endtask : t_bus
  task automatic test_done();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_bus();
    t_async();
    t_soft();
    t_sync();
    test_done();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    miscompares++;
    test_done();
  end
endmodule : test_usart_host_port_mode_setup
`default_nettype wire
